// ---- tmr_consts.svh ----
// Register offsets, field positions, reset values and timing constants of the timer
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH
`define OFS_OPTION_CONFIG 4'h0
`define OFS_IRQ_CONTROL 4'h4
`define OFS_TIMER_COUNT 4'h8
`define OFS_SLEEP_CTRL 4'hC
`define OPTION_RESET 8'hFF
`define IRQ_CONTROL_RESET 8'h00
`define TIMER_COUNT_RESET 8'h00
`define BIT_OVF_FLAG 2
`define BIT_OVF_EN 5
`define WRITE_HOLD_CYCLES 2
`define CLK_PER_INSTR 4
`endif

// ---- tmr_pkg.sv ----
// Types of the timer block
package tmr_pkg;
    typedef struct packed {
        logic pullup_disable;
        logic ext_irq_edge;
        logic count_source_sel;
        logic source_edge_sel;
        logic prescaler_assign;
        logic [2:0] rate_select;
    } option_t;
    typedef enum logic [1:0] {
        PH_ONE = 2'b00,
        PH_TWO = 2'b01,
        PH_THREE = 2'b10,
        PH_FOUR = 2'b11
    } phase_t;
endpackage : tmr_pkg

// ---- tmr_core.sv ----
// Eight-bit timer/counter with watchdog-shared prescaler and Wishbone registers
`timescale 1ns/10ps
`include "tmr_consts.svh"
// Function
// - Source 0 counts instruction cycles
// - Write suppresses counting two instruction cycles
// - Source 1 counts external input edges
// - Edge select 1 falling, 0 rising
// - Prescaler serves timer or watchdog only
// - Rate code sets divide ratio
// - Watchdog-owned prescaler gives timer 1:1
// - Prescaler hidden, cleared by count write when timer-owned
// - Watchdog clear clears owned prescaler
// - Rollover FFh to 00h sets flag
// - Flag held until software clears
// - Interrupt needs flag and enable
// - Sleep freezes the timer
// - Counter sampled on phases two, four
// - Pull-up disable bit exported
// - External interrupt edge bit exported
// - Option resets ones, count kept
module tmr_core import tmr_pkg::*; #(
    parameter int PRESCALE_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic por_i,
    input wire logic [3:0] adr_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    input wire logic we_i,
    input wire logic [3:0] sel_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic ack_o,
    output logic err_o,
    input wire logic ext_count_input_i,
    input wire logic watchdog_clear_instr_i,
    output logic watchdog_tick_o,
    output logic pullup_disable_o,
    output logic ext_irq_edge_o,
    output logic irq_o
);

    option_t opt_r;
    logic [7:0] timer_count_r;
    logic overflow_flag_r;
    logic overflow_irq_en_r;
    logic [5:0] irq_other_r;
    logic sleep_r;
    phase_t phase_r;
    logic [PRESCALE_W-1:0] pre_r;
    logic [1:0] hold_r;
    logic ext_q_r;
    logic ext_edge_r;
    logic pre_out_r;
    logic [7:0] irq_rd;
    logic [7:0] rd_byte;
    // Bus decode and phase strobes
    logic req;
    logic mapped;
    logic wr;
    logic wr_tmr;
    logic wr_irq;
    logic wr_opt;
    logic wr_sleep;
    logic instr_tick;
    logic sample_ph;
    // Count path
    logic ext_rise;
    logic ext_fall;
    logic ext_new;
    logic src_event;
    logic pre_event;
    logic pre_hit;
    logic tmr_inc;
    logic hold_done;
    logic count_step;
    logic rollover;

    assign req = cyc_i && stb_i && !ack_o && !err_o;
    assign mapped = (adr_i == `OFS_OPTION_CONFIG) || (adr_i == `OFS_IRQ_CONTROL) ||
                    (adr_i == `OFS_TIMER_COUNT) || (adr_i == `OFS_SLEEP_CTRL);
    // Writes land at the edge where the master sees ack
    assign wr = cyc_i && stb_i && ack_o && we_i && mapped && sel_i[0];
    assign wr_tmr = wr && (adr_i == `OFS_TIMER_COUNT);
    assign wr_irq = wr && (adr_i == `OFS_IRQ_CONTROL);
    assign wr_opt = wr && (adr_i == `OFS_OPTION_CONFIG);
    assign wr_sleep = wr && (adr_i == `OFS_SLEEP_CTRL);
    assign instr_tick = (phase_r == PH_FOUR);
    // Counter mode looks at the pin twice per instruction
    assign sample_ph = (phase_r == PH_TWO) || instr_tick;

    // Terminal count of the prescaler for a rate code
    function automatic logic pre_term(input logic [PRESCALE_W-1:0] cnt,
                                      input logic [2:0] code, input logic to_watchdog);
        logic [PRESCALE_W-1:0] mask;
        // Four-bit shift amount so code 7 reaches 1:256 for the timer
        mask = PRESCALE_W'((9'h001 << ({1'b0, code} + {3'b000, !to_watchdog})) - 9'h001);
        pre_term = ((cnt & mask) == mask);
    endfunction : pre_term

    // Instruction-cycle phase sequencer, phase one after reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_r <= PH_ONE;
        end else begin
            case (phase_r)
                PH_ONE: begin
                    phase_r <= PH_TWO;
                end
                PH_TWO: begin
                    phase_r <= PH_THREE;
                end
                PH_THREE: begin
                    phase_r <= PH_FOUR;
                end
                PH_FOUR: begin
                    phase_r <= PH_ONE;
                end
                default: begin
                    phase_r <= PH_ONE;
                end
            endcase
        end
    end

    // Pin history for the edge detector
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_q_r <= 1'b0;
        end else begin
            ext_q_r <= ext_count_input_i;
        end
    end

    assign ext_rise = !ext_q_r && ext_count_input_i;
    assign ext_fall = ext_q_r && !ext_count_input_i;
    assign ext_new = opt_r.source_edge_sel ? ext_fall : ext_rise;

    // Edge held until sampled; one arriving in a sample cycle is kept
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_edge_r <= 1'b0;
        end else if (sample_ph) begin
            ext_edge_r <= ext_new;
        end else begin
            ext_edge_r <= ext_edge_r | ext_new;
        end
    end

    assign src_event = opt_r.count_source_sel ? (sample_ph && ext_edge_r) : instr_tick;
    assign pre_event = opt_r.prescaler_assign ? instr_tick : src_event;
    assign pre_hit = pre_event && pre_term(pre_r, opt_r.rate_select, opt_r.prescaler_assign);

    // Shared prescaler, never visible on the bus
    // Clears win over counting so no stale count survives
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pre_r <= '0;
        end else if (wr_tmr && !opt_r.prescaler_assign) begin
            pre_r <= '0;
        end else if (watchdog_clear_instr_i && opt_r.prescaler_assign) begin
            pre_r <= '0;
        end else if (pre_event && !sleep_r) begin
            pre_r <= pre_hit ? '0 : pre_r + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pre_out_r <= 1'b0;
        end else begin
            pre_out_r <= pre_hit && !sleep_r && !opt_r.prescaler_assign;
        end
    end

    // Watchdog gets its divided tick
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            watchdog_tick_o <= 1'b0;
        end else begin
            watchdog_tick_o <= pre_hit && opt_r.prescaler_assign && !sleep_r;
        end
    end

    // undivided source when watchdog owns it
    assign tmr_inc = opt_r.prescaler_assign ? (src_event && !sleep_r) : pre_out_r;

    // Count-write hold in instruction cycles
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_r <= 2'b00;
        end else if (wr_tmr) begin
            hold_r <= 2'(`WRITE_HOLD_CYCLES);
        end else if (instr_tick && hold_r != 2'b00) begin
            hold_r <= hold_r - 2'b01;
        end
    end

    // increments held after a write; frozen asleep
    assign hold_done = (hold_r == 2'b00);
    assign count_step = tmr_inc && hold_done && !sleep_r;

    always_ff @(posedge clk_i) begin
        if (por_i) begin
            timer_count_r <= `TIMER_COUNT_RESET;
        end else if (wr_tmr) begin
            timer_count_r <= dat_i[7:0];
        end else if (count_step) begin
            timer_count_r <= timer_count_r + 8'h01;
        end
    end

    assign rollover = count_step && !wr_tmr && timer_count_r == 8'hFF;

    // rollover sets flag; held until cleared, set wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            overflow_flag_r <= 1'b0;
        end else if (rollover) begin
            overflow_flag_r <= 1'b1;
        end else if (wr_irq && dat_i[`BIT_OVF_FLAG]) begin
            overflow_flag_r <= 1'b0;
        end
    end

    // Overflow interrupt enable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            overflow_irq_en_r <= 1'b0;
        end else if (wr_irq) begin
            overflow_irq_en_r <= dat_i[`BIT_OVF_EN];
        end
    end

    // Remaining control bits, plain storage for other blocks
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_other_r <= 6'h00;
        end else if (wr_irq) begin
            irq_other_r <= {dat_i[7:6], dat_i[4:3], dat_i[1:0]};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            opt_r <= option_t'(`OPTION_RESET);
        end else if (wr_opt) begin
            opt_r <= option_t'(dat_i[7:0]);
        end
    end

    // Sleep control; rst_i wakes the block, por_i alone does not
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sleep_r <= 1'b0;
        end else if (wr_sleep) begin
            sleep_r <= dat_i[0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pullup_disable_o <= 1'b1;
        end else begin
            pullup_disable_o <= opt_r.pullup_disable;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_irq_edge_o <= 1'b1;
        end else begin
            ext_irq_edge_o <= opt_r.ext_irq_edge;
        end
    end

    // request needs flag and enable
    // Registered so the request line never glitches
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= overflow_flag_r && overflow_irq_en_r;
        end
    end

    always_comb begin
        irq_rd = {irq_other_r[5:4], overflow_irq_en_r, irq_other_r[3:2],
                  overflow_flag_r, irq_other_r[1:0]};
    end

    // Read mux over the mapped registers
    always_comb begin
        rd_byte = 8'h00;
        case (adr_i)
            `OFS_OPTION_CONFIG: rd_byte = opt_r;
            `OFS_IRQ_CONTROL: rd_byte = irq_rd;
            `OFS_TIMER_COUNT: rd_byte = timer_count_r;
            `OFS_SLEEP_CTRL: rd_byte = {7'h00, sleep_r};
            default: rd_byte = 8'h00;
        endcase
    end

    // Bus answer one cycle after the request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            err_o <= 1'b0;
        end else begin
            ack_o <= req && mapped;
            err_o <= req && !mapped;
        end
    end

    // Read data stands only with its answer, zero otherwise
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (req && !we_i) begin
            dat_o <= {24'h00_0000, rd_byte};
        end else begin
            dat_o <= 32'h0000_0000;
        end
    end

endmodule : tmr_core

// ---- tmr_core_properties.sv ----
// Port-level checks of the timer block, bound to its top module
`timescale 1ns/10ps
module tmr_core_properties (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic we_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire logic err_o,
    input wire logic pullup_disable_o,
    input wire logic ext_irq_edge_o,
    input wire logic irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic req;
    assign req = cyc_i && stb_i && !ack_o && !err_o;
    chk_answer_next: assert property (req |=> ack_o || err_o) else $error("bus answer missing");
    chk_ack_single: assert property (ack_o |=> !ack_o) else $error("ack held too long");
    chk_err_unmapped: assert property (req && adr_i[1:0] != 2'b00 |=> err_o && !ack_o)
        else $error("bad address not refused");
    chk_pullup_export: assert property (ack_o && we_i && adr_i == 4'h0 |-> ##2
        pullup_disable_o == $past(dat_i[7], 2)) else $error("pull-up bit not exported");
    chk_edge_export: assert property (ack_o && we_i && adr_i == 4'h0 |-> ##2
        ext_irq_edge_o == $past(dat_i[6], 2)) else $error("edge bit not exported");
    chk_reset_option: assert property ($fell(rst_i) |-> pullup_disable_o && ext_irq_edge_o)
        else $error("option bits not set by reset");
    chk_irq_masked: assert property (ack_o && !we_i && adr_i == 4'h4 && !dat_o[5] |=> !irq_o)
        else $error("masked interrupt raised");
    chk_irq_raised: assert property (ack_o && !we_i && adr_i == 4'h4 && dat_o[5] && dat_o[2]
        |=> irq_o) else $error("enabled interrupt missing");
endmodule : tmr_core_properties

bind tmr_core tmr_core_properties u_props (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
    .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
    .err_o(err_o),
    .pullup_disable_o(pullup_disable_o), .ext_irq_edge_o(ext_irq_edge_o), .irq_o(irq_o));

// ---- tmr_far_side.sv ----
// Count pin source that toggles only while asked to run
`timescale 1ns/10ps
module tmr_far_side (
    input wire logic clk_i,
    input wire logic run_i,
    output logic pin_o
);
    logic [2:0] cnt_r = 3'h0;
    logic pin_r = 1'b0;
    assign pin_o = pin_r;
    always @(posedge clk_i) begin
        cnt_r <= run_i ? cnt_r + 3'h1 : 3'h0;
        if (run_i && cnt_r == 3'h7) begin
            pin_r <= !pin_r;
        end
    end
endmodule : tmr_far_side

// ---- tmr_core_tb.sv ----
// Self-checking bench for the timer block
`timescale 1ns/10ps
module tmr_core_tb;
    logic clk_i = 0, rst_i = 1, por_i = 1, we_i = 0, cyc_i = 0, stb_i = 0, run = 0, wdc = 0;
    logic [3:0] adr_i = 4'h0;
    logic [31:0] dat_i = 32'h0000_0000, dat_o, seed = 32'h0000_b425;
    logic ack_o, err_o, pin, irq_o, pu, ie, watchdog_tick;
    logic [7:0] s;
    logic [8:0] q[$];
    int miscompares = 0, check_count = 0, n, e;
    always #50 clk_i = !clk_i;
    tmr_far_side far (.clk_i(clk_i), .run_i(run), .pin_o(pin));
    tmr_core DUT (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .adr_i(adr_i), .dat_i(dat_i),
        .dat_o(dat_o), .we_i(we_i), .sel_i(4'hF), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
        .err_o(err_o), .ext_count_input_i(pin), .watchdog_clear_instr_i(wdc),
        .watchdog_tick_o(watchdog_tick), .pullup_disable_o(pu), .ext_irq_edge_o(ie),
        .irq_o(irq_o));
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude;
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : conclude
    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [8:0] x);
        int k;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {24'h00_0000, d};
        if (!w) q.push_back(x);
        for (k = 0; k < 20 && ack_o !== 1'b1 && err_o !== 1'b1; k++) @(posedge clk_i);
        if (k == 20) begin
            miscompares++;
            conclude();
        end
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask : wb
    // Reads are judged when their answer shows
    always @(posedge clk_i) begin
        if ((ack_o === 1'b1 || err_o === 1'b1) && we_i === 1'b0) begin
            check(err_o ? 9'h100 : {1'b0, dat_o[7:0]}, q.pop_front());
        end
    end
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        por_i <= 1'b0;
        wb(0, 4'h0, 8'h00, 9'h0FF);
        wb(0, 4'h4, 8'h00, 9'h000);
        wb(0, 4'h6, 8'h00, 9'h100);
        // Every rate code with the timer owning the prescaler, then 1:1
        for (int r = 0; r < 9; r++) begin
            seed = lfsr(seed);
            s = {4'hE, seed[3:0]};
            wb(1, 4'h4, 8'h24, 9'h000);
            if (r == 8) begin
                // clear watchdog, clear count, then reassign
                wdc <= 1'b1;
                @(posedge clk_i);
                wdc <= 1'b0;
                wb(1, 4'h8, 8'h00, 9'h000);
            end
            wb(1, 4'h0, r == 8 ? 8'h08 : r[7:0], 9'h000);
            wb(0, 4'h0, 8'h00, r == 8 ? 9'h008 : {1'b0, r[7:0]});
            wb(1, 4'h8, s, 9'h000);
            wb(0, 4'h8, 8'h00, {1'b0, s});
            for (n = 0; n < 40000 && irq_o !== 1'b1; n++) @(posedge clk_i);
            e = 4 * (256 - s) * (r == 8 ? 1 : 2 << r);
            check({8'h00, n >= e - 8 && n <= e + 20}, 9'h001);
            wb(0, 4'h4, 8'h00, 9'h024);
        end
        // Watchdog owns the prescaler at 1:4; a clear restarts its count
        wb(1, 4'h0, 8'h0A, 9'h000);
        for (n = 0; n < 100 && watchdog_tick !== 1'b1; n++) @(posedge clk_i);
        check({8'h00, n < 100}, 9'h001);
        repeat (6) @(posedge clk_i);
        wdc <= 1'b1;
        @(posedge clk_i);
        wdc <= 1'b0;
        for (n = 0; n < 100 && watchdog_tick !== 1'b1; n++) @(posedge clk_i);
        check({8'h00, n >= 12 && n <= 18}, 9'h001);
        wb(1, 4'h4, 8'h00, 9'h000);
        wb(0, 4'h4, 8'h00, 9'h004);
        check({8'h00, irq_o}, 9'h000);
        wb(1, 4'h4, 8'h04, 9'h000);
        wb(0, 4'h4, 8'h00, 9'h000);
        wb(1, 4'h8, 8'h10, 9'h000);
        wb(1, 4'hC, 8'h01, 9'h000);
        repeat (40) @(posedge clk_i);
        wb(0, 4'h8, 8'h00, 9'h010);
        wb(1, 4'hC, 8'h00, 9'h000);
        // Seven pin toggles: three of the chosen edge each time
        for (int m = 0; m < 2; m++) begin
            wb(1, 4'h0, m ? 8'h28 : 8'h38, 9'h000);
            wb(1, 4'h8, 8'h00, 9'h000);
            repeat (8) @(posedge clk_i);
            check({7'h00, pu, ie}, 9'h000);
            run <= 1'b1;
            repeat (56) @(posedge clk_i);
            run <= 1'b0;
            repeat (16) @(posedge clk_i);
            wb(0, 4'h8, 8'h00, 9'h003);
        end
        // Mid-run reset keeps the count and restores the option bits
        wb(1, 4'h8, 8'h5A, 9'h000);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(0, 4'h8, 8'h00, 9'h05A);
        wb(0, 4'h0, 8'h00, 9'h0FF);
        check({7'h00, pu, ie}, 9'h003);
        conclude();
    end
endmodule : tmr_core_tb
